// ==== hdl/acmc_pkg.sv ====
// Constants, types and layout for the calibration mode control block
package acmc_pkg;

   // Register select code of the mode register
   localparam logic [2:0]  ACMC_MODE_REG_SEL = 3'h2;
   localparam logic [15:0] ACMC_MODE_RESET   = 16'h01B0;

   // Operating mode codes
   localparam logic [2:0] ACMC_OP_IDLE     = 3'h0;
   localparam logic [2:0] ACMC_OP_ZS_SELF  = 3'h4;
   localparam logic [2:0] ACMC_OP_FS_SELF  = 3'h5;
   localparam logic [2:0] ACMC_OP_ZS_SYS   = 3'h6;
   localparam logic [2:0] ACMC_OP_FS_SYS   = 3'h7;
   localparam int          ACMC_OP_CAL_BIT  = 2;

   // Calibration source selection for the analog front end
   localparam logic [1:0] ACMC_SRC_INPUT   = 2'h0;
   localparam logic [1:0] ACMC_SRC_SHORTED = 2'h1;
   localparam logic [1:0] ACMC_SRC_FULL    = 2'h2;

   // Sample and calibration store geometry
   localparam int          ACMC_DATA_W      = 24;
   localparam int          ACMC_CAL_AW      = 3;
   localparam logic        ACMC_BANK_OFFSET = 1'b0;
   localparam logic        ACMC_BANK_GAIN   = 1'b1;

   // Mode register field layout, first bit of the stream on top
   typedef struct packed {
      logic [2:0] op_mode;
      logic       unipolar;
      logic       port_output_enable;
      logic       port_out_upper;
      logic       port_out_lower;
      logic       word_len;
      logic       high_ref;
      logic       zero_bit;
      logic [1:0] range_sel;
      logic       clk_disable;
      logic       burnout;
      logic [1:0] channel_select;
   } acmc_mode_t;

   // Write request into the calibration store
   typedef struct packed {
      logic                   we;
      logic [ACMC_CAL_AW-1:0] addr;
      logic [ACMC_DATA_W-1:0] data;
   } acmc_cal_wr_t;

   // Calibration sequencer states
   typedef enum logic [2:0] {
      ACMC_ST_IDLE = 3'b001,
      ACMC_ST_ZERO = 3'b010,
      ACMC_ST_FULL = 3'b100
   } acmc_state_t;

endpackage : acmc_pkg

// ==== hdl/acmc_cal_mem.sv ====
// Offset and gain calibration store, registered read port
module acmc_cal_mem
   import acmc_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire acmc_cal_wr_t           wr,
   input  wire logic [ACMC_CAL_AW-1:0] rd_addr,
   output      logic [ACMC_DATA_W-1:0] rd_data
);

   logic [ACMC_DATA_W-1:0] mem [2**ACMC_CAL_AW];

   // Write port, one entry per cycle
   always_ff @(posedge sys_clk) begin
      if (wr.we) begin
         mem[wr.addr] <= wr.data;
      end
   end

   // Read data held in a register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule : acmc_cal_mem

// ==== hdl/acmc_mode_ctrl.sv ====
// Mode register, calibration sequencer, output coding and port pins
module acmc_mode_ctrl
   import acmc_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   reg_wr,
   input  wire logic [2:0]             reg_sel,
   input  wire logic [15:0]            reg_wdata,
   input  wire logic                   meas_valid,
   input  wire logic [ACMC_DATA_W-1:0] meas_data,
   input  wire logic [ACMC_CAL_AW-1:0] cal_rd_addr,
   output      logic [15:0]            mode_rdata,
   output      logic                   ready_reg,
   output      logic                   mod_reset_reg,
   output      logic [1:0]             cal_source_reg,
   output      logic [1:0]             chan_reg,
   output      logic                   code_valid_reg,
   output      logic [ACMC_DATA_W-1:0] code_reg,
   output      logic                   pin_pos_out,
   output      logic                   pin_pos_oe,
   output      logic                   pin_neg_out,
   output      logic                   pin_neg_oe,
   output      logic [ACMC_DATA_W-1:0] cal_rd_data
);

   acmc_mode_t   mode_reg;
   acmc_mode_t   wr_mode;
   acmc_state_t  state_reg;
   acmc_state_t  state_next;
   acmc_cal_wr_t cal_wr;
   logic         mode_write;
   logic         is_cal_code;
   logic [2:0]   new_op;
   logic         finish;

   assign mode_write  = reg_wr && (reg_sel == ACMC_MODE_REG_SEL);
   assign wr_mode     = acmc_mode_t'(reg_wdata);
   assign new_op      = wr_mode.op_mode;
   assign is_cal_code = new_op[ACMC_OP_CAL_BIT];

   // Sequencer next state; a mode write always takes precedence
   always_comb begin
      state_next = state_reg;
      finish     = 1'b0;
      if (mode_write) begin
         if (!is_cal_code) begin
            state_next = ACMC_ST_IDLE;
         end else if (new_op == ACMC_OP_FS_SYS) begin
            state_next = ACMC_ST_FULL;
         end else begin
            state_next = ACMC_ST_ZERO;
         end
      end else begin
         unique case (state_reg)
            ACMC_ST_IDLE: begin
               state_next = ACMC_ST_IDLE;
            end
            ACMC_ST_ZERO: begin
               if (meas_valid) begin
                  if (mode_reg.op_mode == ACMC_OP_FS_SELF) begin
                     state_next = ACMC_ST_FULL;
                  end else begin
                     state_next = ACMC_ST_IDLE;
                     finish     = 1'b1;
                  end
               end
            end
            ACMC_ST_FULL: begin
               if (meas_valid) begin
                  state_next = ACMC_ST_IDLE;
                  finish     = 1'b1;
               end
            end
            default: begin
               state_next = ACMC_ST_IDLE;
            end
         endcase
      end
   end

   // Calibration result write into the channel's offset or gain entry
   always_comb begin
      cal_wr      = '0;
      cal_wr.data = meas_data;
      if (!mode_write && meas_valid) begin
         if (state_reg == ACMC_ST_ZERO) begin
            cal_wr.we   = 1'b1;
            cal_wr.addr = {ACMC_BANK_OFFSET, mode_reg.channel_select};
         end else if (state_reg == ACMC_ST_FULL) begin
            cal_wr.we   = 1'b1;
            cal_wr.addr = {ACMC_BANK_GAIN, mode_reg.channel_select};
         end
      end
   end

   // Sequencer state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= ACMC_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Mode register: host writes, mode field cleared when calibration ends
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_reg <= acmc_mode_t'(ACMC_MODE_RESET);
      end else if (mode_write) begin
         mode_reg <= acmc_mode_t'(reg_wdata);
      end else if (finish) begin
         mode_reg.op_mode <= ACMC_OP_IDLE;
      end
   end

   // Ready high for the whole calibration, falls with the mode field
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ready_reg <= 1'b0;
      end else if (mode_write) begin
         ready_reg <= is_cal_code;
      end else if (finish) begin
         ready_reg <= 1'b0;
      end
   end

   // Modulator reset while idle, front end source per phase
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mod_reset_reg  <= 1'b1;
         cal_source_reg <= ACMC_SRC_INPUT;
         chan_reg       <= '0;
      end else begin
         mod_reset_reg <= (state_next == ACMC_ST_IDLE) &&
                          (mode_write ? new_op == ACMC_OP_IDLE
                                      : finish ||
                                        mode_reg.op_mode == ACMC_OP_IDLE);
         chan_reg      <= mode_write ? wr_mode.channel_select
                                     : mode_reg.channel_select;
         if (state_next == ACMC_ST_IDLE) begin
            cal_source_reg <= ACMC_SRC_INPUT;
         end else if (mode_write ? new_op == ACMC_OP_ZS_SELF
                                 : mode_reg.op_mode == ACMC_OP_ZS_SELF) begin
            cal_source_reg <= ACMC_SRC_SHORTED;
         end else if ((mode_write ? new_op == ACMC_OP_FS_SELF
                                  : mode_reg.op_mode == ACMC_OP_FS_SELF)) begin
            cal_source_reg <= (state_next == ACMC_ST_ZERO) ? ACMC_SRC_SHORTED
                                                           : ACMC_SRC_FULL;
         end else begin
            cal_source_reg <= ACMC_SRC_INPUT;
         end
      end
   end

   // Output coding of conversion samples, two's complement in
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         code_valid_reg <= 1'b0;
         code_reg       <= '0;
      end else begin
         code_valid_reg <= meas_valid && (state_reg == ACMC_ST_IDLE) &&
                           !mod_reset_reg;
         if (meas_valid) begin
            if (!mode_reg.unipolar) begin
               code_reg <= {~meas_data[ACMC_DATA_W-1],
                            meas_data[ACMC_DATA_W-2:0]};
            end else if (meas_data[ACMC_DATA_W-1]) begin
               code_reg <= '0;
            end else begin
               // Top bit copied down so full scale reaches all ones
               code_reg <= {meas_data[ACMC_DATA_W-2:0],
                            meas_data[ACMC_DATA_W-2]};
            end
         end
      end
   end

   // Port pins: driven and held while port output is enabled
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pin_pos_out <= 1'b0;
         pin_pos_oe  <= 1'b0;
         pin_neg_out <= 1'b0;
         pin_neg_oe  <= 1'b0;
      end else begin
         pin_pos_oe  <= mode_reg.port_output_enable;
         pin_neg_oe  <= mode_reg.port_output_enable;
         pin_pos_out <= mode_reg.port_output_enable &
                        mode_reg.port_out_upper;
         pin_neg_out <= mode_reg.port_output_enable &
                        mode_reg.port_out_lower;
      end
   end

   assign mode_rdata = mode_reg;

   // Calibration store
   acmc_cal_mem u_cal_mem (
      .sys_clk (sys_clk),
      .rst     (rst),
      .wr      (cal_wr),
      .rd_addr (cal_rd_addr),
      .rd_data (cal_rd_data)
   );

endmodule : acmc_mode_ctrl

// ==== test/acmc_mode_monitor.sv ====
// Port checks for the mode control block
module acmc_mode_monitor
   import acmc_pkg::*;
(
   input wire logic                   sys_clk,
   input wire logic                   rst,
   input wire logic                   reg_wr,
   input wire logic [2:0]             reg_sel,
   input wire logic [15:0]            reg_wdata,
   input wire logic                   meas_valid,
   input wire logic [ACMC_DATA_W-1:0] meas_data,
   input wire logic [15:0]            mode_rdata,
   input wire logic                   ready_reg,
   input wire logic                   mod_reset_reg,
   input wire logic [1:0]             cal_source_reg,
   input wire logic [ACMC_DATA_W-1:0] code_reg,
   input wire logic                   pin_pos_out,
   input wire logic                   pin_pos_oe,
   input wire logic                   pin_neg_out,
   input wire logic                   pin_neg_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Decoded mode write, current mode, final calibration sample
   logic       wr;
   logic [2:0] op;
   logic       last;
   assign wr = reg_wr && (reg_sel == ACMC_MODE_REG_SEL);
   assign op = mode_rdata[15:13];
   assign last = !(op == ACMC_OP_FS_SELF && cal_source_reg == ACMC_SRC_SHORTED);
   cal_start_a: assert property (wr && reg_wdata[15] |=> ready_reg &&
      op == $past(reg_wdata[15:13]) && !mod_reset_reg) else $error("no start");
   cal_source_a: assert property (wr && reg_wdata[15] |=> cal_source_reg ==
      ($past(reg_wdata[14]) ? ACMC_SRC_INPUT : ACMC_SRC_SHORTED)) else $error("bad source");
   full_step_a: assert property (!wr && meas_valid && ready_reg && !last |=>
      ready_reg && cal_source_reg == ACMC_SRC_FULL) else $error("bad full step");
   cal_end_a: assert property (!wr && meas_valid && ready_reg && last |=>
      !ready_reg && op == ACMC_OP_IDLE && mod_reset_reg) else $error("no finish");
   ready_mode_a: assert property (ready_reg == op[ACMC_OP_CAL_BIT])
      else $error("ready and mode disagree");
   idle_hold_a: assert property (op == ACMC_OP_IDLE |-> mod_reset_reg)
      else $error("idle not held");
   pin_enable_a: assert property (pin_pos_oe == $past(mode_rdata[11]) &&
      pin_neg_oe == $past(mode_rdata[11])) else $error("bad pin enable");
   pin_level_a: assert property (pin_pos_out == $past(&mode_rdata[11:10]) &&
      pin_neg_out == $past(mode_rdata[11] & mode_rdata[9])) else $error("bad pin");
   bipolar_code_a: assert property (meas_valid && !mode_rdata[12] |=> code_reg ==
      {~$past(meas_data[23]), $past(meas_data[22:0])}) else $error("bad bipolar");
   unipolar_code_a: assert property (meas_valid && mode_rdata[12] |=> code_reg ==
      ($past(meas_data[23]) ? '0 : {$past(meas_data[22:0]), $past(meas_data[22])}))
      else $error("bad unipolar");
endmodule : acmc_mode_monitor

bind acmc_mode_ctrl acmc_mode_monitor mon (.sys_clk, .rst, .reg_wr, .reg_sel,
   .reg_wdata, .meas_valid, .meas_data, .mode_rdata, .ready_reg, .mod_reset_reg,
   .cal_source_reg, .code_reg, .pin_pos_out, .pin_pos_oe, .pin_neg_out, .pin_neg_oe);

// ==== test/acmc_host_model.sv ====
// Host controller model writing the mode register
module acmc_host_model
   import acmc_pkg::*;
(
   input  wire logic        sys_clk,
   output      logic        reg_wr,
   output      logic [2:0]  reg_sel,
   output      logic [15:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      reg_wr = 1'b0;
      reg_sel = 3'h0;
      reg_wdata = 16'h0000;
   end
   // One write strobe; select and data scrambled once released
   task automatic put(input logic [2:0] s, input logic [15:0] w);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_sel <= s;
      reg_wdata <= w & 16'hffbf;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_sel <= ~s;
      reg_wdata <= ~w;
   endtask : put
endmodule : acmc_host_model

// ==== test/test_adc_calibration_mode_control.sv ====
// Self-checking bench for the mode control block
module test_adc_calibration_mode_control
   import acmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
   $display("Error %0t: got %h want %h", $time, (a), (b)); end end
   logic                   sys_clk = 1'b0, rst = 1'b1, meas_valid = 1'b0;
   logic [ACMC_DATA_W-1:0] meas_data = '0, code_reg, cal_rd_data, smp;
   logic [ACMC_DATA_W-1:0] shadow [8];
   logic [ACMC_CAL_AW-1:0] cal_rd_addr = '0;
   logic [15:0]            reg_wdata, mode_rdata;
   logic [3:0]             cfg;
   logic [2:0]             reg_sel;
   logic [2:0]             ops [4] = '{3'h5, 3'h4, 3'h6, 3'h7};
   logic [1:0]             cal_source_reg, chan_reg;
   logic                   reg_wr, ready_reg, mod_reset_reg, code_valid_reg;
   logic                   pin_pos_out, pin_pos_oe, pin_neg_out, pin_neg_oe;
   int                     num_errors = 0, checks_done = 0, cyc = 0;
   int                     seed = 32'h07d6_d568;
   always #50 sys_clk = ~sys_clk;
   acmc_host_model host (.sys_clk, .reg_wr, .reg_sel, .reg_wdata);
   acmc_mode_ctrl dut (.sys_clk, .rst, .reg_wr, .reg_sel, .reg_wdata,
      .meas_valid, .meas_data, .cal_rd_addr, .mode_rdata, .ready_reg,
      .mod_reset_reg, .cal_source_reg, .chan_reg, .code_valid_reg, .code_reg,
      .pin_pos_out, .pin_pos_oe, .pin_neg_out, .pin_neg_oe, .cal_rd_data);
   // Mode word with fixed reference, range and word length fields
   function automatic logic [15:0] mw(logic [2:0] o, logic [3:0] c,
                                      logic [1:0] ch);
      return {o, c, 7'h6c, ch};
   endfunction : mw
   // Expected output code for a sample and polarity bit
   function automatic logic [23:0] cexp(logic [23:0] d, logic u);
      if (!u) return {~d[23], d[22:0]};
      if (d[23]) return '0;
      return {d[22:0], d[22]};
   endfunction : cexp
   // One filtered sample pulse
   task automatic pulse(input logic [ACMC_DATA_W-1:0] d);
      @(posedge sys_clk);
      meas_valid <= 1'b1;
      meas_data <= d;
      @(posedge sys_clk);
      meas_valid <= 1'b0;
      meas_data <= ~d;
      #1;
   endtask : pulse
   // Calibration store entry against the bench copy
   task automatic rd_cal(input int a);
      @(posedge sys_clk);
      cal_rd_addr <= a[2:0];
      @(posedge sys_clk);
      #1;
      `CHK(cal_rd_data, shadow[a])
   endtask : rd_cal
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude
   // Cycle ceiling against hangs
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         conclude();
      end
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      `CHK(mode_rdata, ACMC_MODE_RESET)
      `CHK({ready_reg, mod_reset_reg, pin_pos_oe}, 3'b010)
      for (int c = 0; c < 4; c++) begin
         foreach (ops[i]) begin
            host.put(ACMC_MODE_REG_SEL, mw(ops[i], 4'h0, c[1:0]));
            #1;
            `CHK({ready_reg, mode_rdata[15:13], chan_reg}, {1'b1, ops[i], c[1:0]})
            smp = 24'($random(seed));
            pulse(smp);
            if (ops[i] == ACMC_OP_FS_SELF) begin
               shadow[c] = smp;
               smp = 24'($random(seed));
               pulse(smp);
            end
            shadow[{ops[i][0], c[1:0]}] = smp;
            `CHK({ready_reg, mode_rdata[15:13]}, 4'h0)
            `CHK(code_valid_reg, 1'b0)
            rd_cal(c);
            rd_cal(4 + c);
         end
      end
      host.put(ACMC_MODE_REG_SEL, mw(ACMC_OP_ZS_SELF, 4'h0, 2'h1));
      host.put(ACMC_MODE_REG_SEL, mw(ACMC_OP_ZS_SYS, 4'h0, 2'h2));
      host.put(3'h3, mw(ACMC_OP_IDLE, 4'h0, 2'h0));
      #1;
      `CHK({ready_reg, mode_rdata[15:13], cal_source_reg}, 6'h38)
      smp = 24'($random(seed));
      pulse(smp);
      shadow[2] = smp;
      rd_cal(2);
      rd_cal(6);
      for (int k = 0; k < 8; k++) begin
         cfg = 4'($random(seed));
         host.put(ACMC_MODE_REG_SEL, mw(3'h1, cfg, 2'h0));
         @(posedge sys_clk);
         #1;
         `CHK({pin_pos_oe, pin_pos_out, pin_neg_oe, pin_neg_out}, {cfg[2], &cfg[2:1], cfg[2], cfg[2] & cfg[0]})
         smp = 24'($random(seed));
         smp = k == 0 ? 24'h80_0000 : k == 1 ? 24'h7f_ffff :
               k == 2 ? 24'h00_0000 : smp;
         pulse(smp);
         `CHK({code_valid_reg, code_reg}, {1'b1, cexp(smp, cfg[3])})
      end
      conclude();
   end
endmodule : test_adc_calibration_mode_control
